// ### rtl/ald_defines.svh
// constants for the five-channel audio link dma engine
// assumes: included by bare name; definitions only
`ifndef ALD_DEFINES_SVH
`define ALD_DEFINES_SVH
`define ALD_NCH 5
`define ALD_OUT_MASK 5'h12
`define ALD_FIFO_DEEP 4
`define ALD_FIFO_SHALLOW 2
`define ALD_WORD_W 32
`define ALD_SMP_W 16
`define ALD_REG_BASE 2'h0
`define ALD_REG_LVI 2'h1
`define ALD_REG_STAT 2'h2
`define ALD_REG_CTRL 2'h3
`define ALD_CTRL_RUN 0
`define ALD_CTRL_IOCIE 2
`define ALD_CTRL_FEIE 3
`define ALD_ST_HALT 0
`define ALD_ST_IOC 2
`define ALD_ST_FE 4
`define ALD_ST_CIV 8
`define ALD_DESC_IOC 31
`define ALD_DESC_BUP 30
`define ALD_DESC_CTL_OFS 32'h4
`define ALD_WORD_BYTES 32'h4
`define ALD_CH_LSB 4
`define ALD_MAP_TOP 7
`define ALD_RESP_OKAY 2'h0
`define ALD_RESP_SLVERR 2'h2
`endif

// ### rtl/ald_pkg.sv
// types shared by the audio link dma engine files
// assumes: compiled before any module that imports it
package ald_pkg;
    typedef enum logic [0:0] {ENG_IDLE = 1'b0, ENG_BUSY = 1'b1} ald_eng_t;
    typedef enum logic [1:0]
    {
        PH_PTR = 2'b00,
        PH_CTL = 2'b01,
        PH_DATA = 2'b10
    } ald_phase_t;
endpackage

// ### rtl/ald_fifo.sv
// small sample fifo; storage in flip-flops, head word always presented
// assumes: caller gates push and pop with its clock enable
`timescale 1ns/1ps
module ald_fifo #(parameter int W = 32, parameter int DEPTH = 4)
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic push_i,
    output logic push_ready_o,
    input wire logic [W-1:0] push_data_i,
    input wire logic pop_i,
    output logic pop_valid_o,
    output logic [W-1:0] pop_data_o
);
    localparam int AW = (DEPTH > 2) ? $clog2(DEPTH) : 1;
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wptr, rptr;
    logic [AW:0] cnt;
    logic do_push, do_pop;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign push_ready_o = (cnt != (AW + 1)'(DEPTH));
    assign pop_valid_o = (cnt != '0);
    assign pop_data_o = mem[rptr];
    assign do_push = push_i && push_ready_o;
    assign do_pop = pop_i && pop_valid_o;

    always_ff @(posedge clk_i)
    begin
        if (do_push)
            mem[wptr] <= push_data_i;
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            wptr <= '0;
            rptr <= '0;
            cnt <= '0;
        end
        else
        begin
            if (do_push)
                wptr <= bump(wptr);
            if (do_pop)
                rptr <= bump(rptr);
            if (do_push && !do_pop)
                cnt <= cnt + 1'b1;
            else if (do_pop && !do_push)
                cnt <= cnt - 1'b1;
        end
    end
endmodule

// ### rtl/ald_rr_arb.sv
// round-robin arbiter; grant is combinational, pointer moves on take
// assumes: take_i is high only in a cycle where a grant is used
`timescale 1ns/1ps
module ald_rr_arb #(parameter int N = 5)
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [N-1:0] req_i,
    input wire logic take_i,
    output logic [N-1:0] gnt_o
);
    localparam int IW = $clog2(N);
    logic [IW-1:0] last;

    always_comb
    begin
        gnt_o = '0;
        for (int k = 1; k <= N; k++)
            if (gnt_o == '0 && req_i[(int'(last) + k) % N])
                gnt_o[(int'(last) + k) % N] = 1'b1;
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            last <= IW'(N - 1);
        else if (take_i)
            for (int i = 0; i < N; i++)
                if (gnt_o[i])
                    last <= IW'(i);
    end
endmodule

// ### rtl/ald_dma.sv
// five-channel scatter/gather dma between memory and link sample slots
// assumes: axi4-lite slave, single-beat memory port held until ack
`timescale 1ns/1ps
`include "ald_defines.svh"
module ald_dma import ald_pkg::*; #(parameter int AXI_AW = 8)
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic [AXI_AW-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [AXI_AW-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic mem_req_o,
    output logic mem_we_o,
    output logic [31:0] mem_addr_o,
    output logic [31:0] mem_wdata_o,
    input wire logic mem_ack_i,
    input wire logic [31:0] mem_rdata_i,
    input wire logic [`ALD_NCH-1:0] slot_req_i,
    output logic [`ALD_NCH*`ALD_SMP_W-1:0] slot_data_o,
    output logic [`ALD_NCH-1:0] slot_valid_o,
    input wire logic [`ALD_NCH-1:0] slot_in_valid_i,
    input wire logic [`ALD_NCH*`ALD_SMP_W-1:0] slot_in_data_i,
    output logic [`ALD_NCH-1:0] irq_o
);
    localparam logic [`ALD_NCH-1:0] IS_OUT = `ALD_OUT_MASK;

    logic [`ALD_NCH-1:0][28:0] bdbar;
    logic [`ALD_NCH-1:0][4:0] last_valid_index, civ;
    logic [`ALD_NCH-1:0][31:0] bufp;
    logic [`ALD_NCH-1:0][15:0] rem, lo_hold, last_smp;
    logic [`ALD_NCH-1:0] run, fe_ie, ioc_ie, st_ioc, st_fe, halted, at_lvi;
    logic [`ALD_NCH-1:0] lvi_wr, ioc_d, bup_d, ioc_set, fe_set, half;
    logic [`ALD_NCH-1:0] req, gnt, f_push, f_rdy, f_pop, f_vld;
    logic [`ALD_NCH-1:0][31:0] f_wd, f_rd;
    ald_phase_t ph [`ALD_NCH];
    ald_eng_t eng;
    logic [2:0] cur, gidx, wr_ch, rd_ch;
    logic [1:0] wr_rg, rd_rg;
    logic wr_en, wr_ok, rd_ok, eng_ack, eng_fin;
    logic [31:0] wr_val;

    function automatic logic [2:0] oh2idx(input logic [`ALD_NCH-1:0] v);
        oh2idx = '0;
        for (int i = 0; i < `ALD_NCH; i++)
            if (v[i])
                oh2idx = 3'(i);
    endfunction

    function automatic logic addr_ok(input logic [AXI_AW-1:0] a);
        return ((a >> `ALD_MAP_TOP) == '0) && (a[6:`ALD_CH_LSB] < 3'(`ALD_NCH));
    endfunction

    function automatic logic [31:0] desc_addr(input logic [2:0] c);
        return {bdbar[c], 3'h0} + {24'h0, civ[c], 3'h0};
    endfunction

    function automatic logic [31:0] reg_read(input logic [2:0] c, input logic [1:0] rg);
        reg_read = '0;
        unique case (rg)
            `ALD_REG_BASE: reg_read = {bdbar[c], 3'h0};
            `ALD_REG_LVI: reg_read[4:0] = last_valid_index[c];
            `ALD_REG_STAT:
            begin
                reg_read[`ALD_ST_HALT] = halted[c];
                reg_read[`ALD_ST_IOC] = st_ioc[c];
                reg_read[`ALD_ST_FE] = st_fe[c];
                reg_read[`ALD_ST_CIV +: 5] = civ[c];
            end
            `ALD_REG_CTRL:
            begin
                reg_read[`ALD_CTRL_RUN] = run[c];
                reg_read[`ALD_CTRL_IOCIE] = ioc_ie[c];
                reg_read[`ALD_CTRL_FEIE] = fe_ie[c];
            end
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // register bus slave

    assign wr_ch = s_axi_awaddr_i[6:`ALD_CH_LSB];
    assign wr_rg = s_axi_awaddr_i[3:2];
    assign rd_ch = s_axi_araddr_i[6:`ALD_CH_LSB];
    assign rd_rg = s_axi_araddr_i[3:2];
    assign wr_ok = addr_ok(s_axi_awaddr_i);
    assign rd_ok = addr_ok(s_axi_araddr_i);
    assign wr_en = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;

    always_comb
    begin
        wr_val = wr_ok ? reg_read(wr_ch, wr_rg) : '0;
        for (int b = 0; b < 4; b++)
            if (s_axi_wstrb_i[b])
                wr_val[b*8 +: 8] = s_axi_wdata_i[b*8 +: 8];
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o <= 1'b0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= `ALD_RESP_OKAY;
        end
        else if (ce_i)
        begin
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o <= 1'b0;
            if (s_axi_awvalid_i && s_axi_wvalid_i && !s_axi_awready_o && !s_axi_bvalid_o)
            begin
                s_axi_awready_o <= 1'b1;
                s_axi_wready_o <= 1'b1;
            end
            if (wr_en)
            begin
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= wr_ok ? `ALD_RESP_OKAY : `ALD_RESP_SLVERR;
            end
            else if (s_axi_bvalid_o && s_axi_bready_i)
                s_axi_bvalid_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= '0;
            s_axi_rresp_o <= `ALD_RESP_OKAY;
        end
        else if (ce_i)
        begin
            s_axi_arready_o <= s_axi_arvalid_i && !s_axi_arready_o && !s_axi_rvalid_o;
            if (s_axi_arvalid_i && s_axi_arready_o)
            begin
                s_axi_rvalid_o <= 1'b1;
                s_axi_rdata_o <= rd_ok ? reg_read(rd_ch, rd_rg) : '0;
                s_axi_rresp_o <= rd_ok ? `ALD_RESP_OKAY : `ALD_RESP_SLVERR;
            end
            else if (s_axi_rvalid_o && s_axi_rready_i)
                s_axi_rvalid_o <= 1'b0;
        end
    end

    // software-written controls
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            bdbar <= '0;
            last_valid_index <= '0;
            run <= '0;
            ioc_ie <= '0;
            fe_ie <= '0;
            lvi_wr <= '0;
        end
        else if (ce_i)
        begin
            lvi_wr <= '0;
            if (wr_en && wr_ok)
            begin
                unique case (wr_rg)
                    `ALD_REG_BASE: bdbar[wr_ch] <= wr_val[31:3];
                    `ALD_REG_LVI:
                    begin
                        last_valid_index[wr_ch] <= wr_val[4:0];
                        lvi_wr[wr_ch] <= 1'b1;
                    end
                    `ALD_REG_CTRL:
                    begin
                        run[wr_ch] <= wr_val[`ALD_CTRL_RUN];
                        ioc_ie[wr_ch] <= wr_val[`ALD_CTRL_IOCIE];
                        fe_ie[wr_ch] <= wr_val[`ALD_CTRL_FEIE];
                    end
                    `ALD_REG_STAT: ;
                endcase
            end
        end
    end

    // sticky status, set wins over write-one-to-clear
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st_ioc <= '0;
            st_fe <= '0;
            halted <= '1;
            irq_o <= '0;
        end
        else if (ce_i)
            for (int c = 0; c < `ALD_NCH; c++)
            begin
                st_ioc[c] <= ioc_set[c] | (st_ioc[c] & ~(wr_en && wr_ok && wr_ch == 3'(c)
                    && wr_rg == `ALD_REG_STAT && wr_val[`ALD_ST_IOC]));
                st_fe[c] <= fe_set[c] | (st_fe[c] & ~(wr_en && wr_ok && wr_ch == 3'(c)
                    && wr_rg == `ALD_REG_STAT && wr_val[`ALD_ST_FE]));
                halted[c] <= (!run[c] || at_lvi[c]) && !(eng == ENG_BUSY && cur == 3'(c));
                irq_o[c] <= (st_ioc[c] && ioc_ie[c]) || (st_fe[c] && fe_ie[c]);
            end
    end

    ////////////////////////////////////////////////////////////////////////////
    // descriptor and data engine

    always_comb
        for (int c = 0; c < `ALD_NCH; c++)
            req[c] = run[c] && !at_lvi[c] && (ph[c] != PH_DATA || (rem[c] != '0 &&
                (IS_OUT[c] ? f_rdy[c] : f_vld[c])));

    ald_rr_arb #(.N(`ALD_NCH)) u_arb
    (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .req_i(req),
        .take_i(ce_i && eng == ENG_IDLE && gnt != '0),
        .gnt_o(gnt)
    );

    assign gidx = oh2idx(gnt);
    assign eng_ack = eng == ENG_BUSY && mem_ack_i;
    assign eng_fin = eng_ack && ((ph[cur] == PH_CTL && mem_rdata_i[15:0] == '0)
        || (ph[cur] == PH_DATA && rem[cur] == 16'h1));

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            eng <= ENG_IDLE;
            cur <= '0;
            mem_req_o <= 1'b0;
            mem_we_o <= 1'b0;
            mem_addr_o <= '0;
            mem_wdata_o <= '0;
            civ <= '0;
            at_lvi <= '0;
            bufp <= '0;
            rem <= '0;
            ioc_d <= '0;
            bup_d <= '0;
            ioc_set <= '0;
            for (int c = 0; c < `ALD_NCH; c++)
                ph[c] <= PH_PTR;
        end
        else if (ce_i)
        begin
            ioc_set <= '0;
            for (int c = 0; c < `ALD_NCH; c++)
                if (lvi_wr[c] && at_lvi[c] && run[c] && last_valid_index[c] != civ[c])
                begin
                    civ[c] <= civ[c] + 5'h1;
                    ph[c] <= PH_PTR;
                    at_lvi[c] <= 1'b0;
                end
            unique case (eng)
                ENG_IDLE:
                    if (gnt != '0)
                    begin
                        cur <= gidx;
                        mem_req_o <= 1'b1;
                        eng <= ENG_BUSY;
                        mem_we_o <= 1'b0;
                        unique case (ph[gidx])
                            PH_PTR: mem_addr_o <= desc_addr(gidx);
                            PH_CTL: mem_addr_o <= desc_addr(gidx) + `ALD_DESC_CTL_OFS;
                            PH_DATA:
                            begin
                                mem_addr_o <= bufp[gidx];
                                mem_we_o <= !IS_OUT[gidx];
                                mem_wdata_o <= f_rd[gidx];
                            end
                            default: mem_addr_o <= desc_addr(gidx);
                        endcase
                    end
                ENG_BUSY:
                    if (mem_ack_i)
                    begin
                        mem_req_o <= 1'b0;
                        eng <= ENG_IDLE;
                        unique case (ph[cur])
                            PH_PTR:
                            begin
                                bufp[cur] <= {mem_rdata_i[31:2], 2'h0};
                                ph[cur] <= PH_CTL;
                            end
                            PH_CTL:
                            begin
                                ioc_d[cur] <= mem_rdata_i[`ALD_DESC_IOC];
                                bup_d[cur] <= mem_rdata_i[`ALD_DESC_BUP];
                                rem[cur] <= 16'(({1'b0, mem_rdata_i[15:0]} + 17'h1) >> 1);
                                ph[cur] <= PH_DATA;
                            end
                            PH_DATA:
                            begin
                                bufp[cur] <= bufp[cur] + `ALD_WORD_BYTES;
                                rem[cur] <= rem[cur] - 16'h1;
                            end
                            default: ph[cur] <= PH_PTR;
                        endcase
                        if (eng_fin)
                        begin
                            ioc_set[cur] <= (ph[cur] == PH_CTL) ? mem_rdata_i[`ALD_DESC_IOC]
                                : ioc_d[cur];
                            ph[cur] <= PH_PTR;
                            if (civ[cur] == last_valid_index[cur])
                                at_lvi[cur] <= 1'b1;
                            else
                                civ[cur] <= civ[cur] + 5'h1;
                        end
                    end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sample fifos and link slots

    always_comb
        for (int c = 0; c < `ALD_NCH; c++)
        begin
            f_push[c] = ce_i && (IS_OUT[c]
                ? (eng_ack && cur == 3'(c) && ph[c] == PH_DATA)
                : (slot_in_valid_i[c] && run[c] && half[c]));
            f_wd[c] = IS_OUT[c] ? mem_rdata_i
                : {slot_in_data_i[c*`ALD_SMP_W +: `ALD_SMP_W], lo_hold[c]};
            f_pop[c] = ce_i && (IS_OUT[c] ? (slot_req_i[c] && half[c])
                : (eng == ENG_IDLE && gnt[c] && ph[c] == PH_DATA));
        end

    for (genvar g = 0; g < `ALD_NCH; g++)
    begin : g_fifo
        ald_fifo #(
            .W(`ALD_WORD_W),
            .DEPTH((g < 2) ? `ALD_FIFO_DEEP : `ALD_FIFO_SHALLOW)
        ) u_fifo
        (
            .clk_i(clk_i),
            .resetn_i(resetn_i),
            .push_i(f_push[g]),
            .push_ready_o(f_rdy[g]),
            .push_data_i(f_wd[g]),
            .pop_i(f_pop[g]),
            .pop_valid_o(f_vld[g]),
            .pop_data_o(f_rd[g])
        );
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            half <= '0;
            lo_hold <= '0;
            last_smp <= '0;
            slot_data_o <= '0;
            slot_valid_o <= '0;
            fe_set <= '0;
        end
        else if (ce_i)
        begin
            fe_set <= '0;
            for (int c = 0; c < `ALD_NCH; c++)
                if (IS_OUT[c] && slot_req_i[c])
                begin
                    slot_valid_o[c] <= run[c];
                    if (f_vld[c])
                    begin
                        slot_data_o[c*`ALD_SMP_W +: `ALD_SMP_W] <= half[c]
                            ? f_rd[c][31:16] : f_rd[c][15:0];
                        last_smp[c] <= half[c] ? f_rd[c][31:16] : f_rd[c][15:0];
                        half[c] <= !half[c];
                    end
                    else
                    begin
                        slot_data_o[c*`ALD_SMP_W +: `ALD_SMP_W] <= (at_lvi[c] && bup_d[c])
                            ? '0 : last_smp[c];
                        fe_set[c] <= run[c];
                    end
                end
                else if (!IS_OUT[c] && slot_in_valid_i[c] && run[c])
                begin
                    half[c] <= !half[c];
                    if (!half[c])
                        lo_hold[c] <= slot_in_data_i[c*`ALD_SMP_W +: `ALD_SMP_W];
                    else if (!f_rdy[c])
                        fe_set[c] <= 1'b1;
                end
        end
    end
endmodule

// ### test/ald_dma_props.sv
// assertion checker for the audio link dma engine
// assumes: bound to ald_dma, sees its ports only
`timescale 1ns/1ps
`include "ald_defines.svh"
module ald_dma_props
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic s_axi_rvalid_o,
    input wire logic mem_req_o,
    input wire logic mem_ack_i,
    input wire logic [31:0] mem_addr_o,
    input wire logic [`ALD_NCH-1:0] slot_valid_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);
    sequence wr_take_s;
        s_axi_awvalid_i && s_axi_awready_o;
    endsequence
    wr_resp_a: assert property (wr_take_s |=> s_axi_bvalid_o)
        else $error("write response missing");
    b_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
        else $error("write response dropped early");
    wr_block_a: assert property (s_axi_bvalid_o |-> !s_axi_awready_o)
        else $error("write taken during response");
    rd_resp_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read response missing");
    mem_hold_a: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o))
        else $error("memory request not held");
    mem_drop_a: assert property (mem_ack_i |=> !mem_req_o)
        else $error("memory request kept after ack");
    mem_align_a: assert property (mem_req_o |-> mem_addr_o[1:0] == 2'b00)
        else $error("memory access not word aligned");
    in_slots_a: assert property ((slot_valid_o & 5'h0d) == 5'h00)
        else $error("input channel tags output slot");
endmodule
bind ald_dma ald_dma_props i_props (.clk_i, .resetn_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o,
    .mem_req_o, .mem_ack_i, .mem_addr_o, .slot_valid_o);

// ### test/ald_mem_model.sv
// system memory seen by the dma master port, 64 words
// assumes: one access at a time, request held until ack
`timescale 1ns/1ps
module ald_mem_model
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic req_i,
    input wire logic we_i,
    input wire logic [31:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic [1:0] dly_i,
    output logic ack_o,
    output logic [31:0] rdata_o
);
    logic [31:0] mem [0:63];
    logic [1:0] cnt;
    // data bus toggles when not answering
    always @(posedge clk_i or negedge resetn_i)
        if (!resetn_i)
        begin
            ack_o <= 1'b0;
            cnt <= 2'h0;
            rdata_o <= 32'h0;
        end
        else if (req_i && !ack_o && cnt == dly_i)
        begin
            ack_o <= 1'b1;
            cnt <= 2'h0;
            rdata_o <= mem[addr_i[7:2]];
            if (we_i)
                mem[addr_i[7:2]] <= wdata_i;
        end
        else
        begin
            ack_o <= 1'b0;
            cnt <= (req_i && !ack_o) ? cnt + 2'h1 : 2'h0;
            rdata_o <= ~rdata_o;
        end
endmodule

// ### test/ald_dma_tb.sv
// self-checking bench for the audio link dma engine
// assumes: memory model answers the master port
`timescale 1ns/1ps
`include "ald_defines.svh"
module ald_dma_tb;
    logic clk_i = 0, resetn_i = 0, ce_i = 1, s_axi_awvalid_i = 0, s_axi_wvalid_i = 0;
    logic s_axi_bready_i = 0, s_axi_arvalid_i = 0, s_axi_rready_i = 0;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic mem_req_o, mem_we_o, mem_ack_i;
    logic [7:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0;
    logic [31:0] s_axi_wdata_i = 0, s_axi_rdata_o, mem_addr_o, mem_wdata_o, mem_rdata_i, rd;
    logic [3:0] s_axi_wstrb_i = 4'hf;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rsp, dly = 0;
    logic [`ALD_NCH-1:0] slot_req_i = 0, slot_valid_o, slot_in_valid_i = 0, irq_o;
    logic [`ALD_NCH*`ALD_SMP_W-1:0] slot_data_o, slot_in_data_i = 0;
    int err_total = 0, n_tests = 0;
    always #4 clk_i = ~clk_i;
    ald_dma i_ald_dma (.*);
    ald_mem_model i_ald_mem_model (.clk_i, .resetn_i, .req_i(mem_req_o), .we_i(mem_we_o),
        .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .dly_i(dly), .ack_o(mem_ack_i),
        .rdata_o(mem_rdata_i));
    ////////////////////////////////////////
    task automatic chk(input bit ok, input string m);
        n_tests++;
        if (!ok)
        begin
            err_total++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask
    task automatic summarize;
        $display("checks %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic guard(input int n);
        if (n >= 60)
        begin
            chk(0, "handshake timeout");
            summarize();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        logic aw_done, w_done;
        n = 0;
        aw_done = 1'b0;
        w_done = 1'b0;
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        do
        begin
            @(posedge clk_i);
            if (s_axi_awready_o)
            begin
                aw_done = 1'b1;
                s_axi_awvalid_i <= 1'b0;
            end
            if (s_axi_wready_o)
            begin
                w_done = 1'b1;
                s_axi_wvalid_i <= 1'b0;
            end
        end
        while (!(aw_done && w_done) && ++n < 60);
        do
            @(posedge clk_i);
        while (!s_axi_bvalid_o && ++n < 60);
        rsp = s_axi_bresp_o;
        s_axi_bready_i <= 1'b0;
        @(posedge clk_i);
        guard(n);
    endtask
    task automatic rdr(input logic [7:0] a);
        int n;
        n = 0;
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        do
            @(posedge clk_i);
        while (!s_axi_arready_o && ++n < 60);
        s_axi_arvalid_i <= 1'b0;
        do
            @(posedge clk_i);
        while (!s_axi_rvalid_o && ++n < 60);
        rd = s_axi_rdata_o;
        rsp = s_axi_rresp_o;
        s_axi_rready_i <= 1'b0;
        @(posedge clk_i);
        guard(n);
    endtask
    task automatic poll(input logic [7:0] a, input int b);
        int n;
        n = 0;
        do
            rdr(a);
        while (!rd[b] && ++n < 60);
        guard(n);
    endtask
    task automatic req_out(input int c);
        slot_req_i[c] <= 1'b1;
        @(posedge clk_i);
        slot_req_i[c] <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic smp_in(input int c, input logic [15:0] v);
        slot_in_valid_i[c] <= 1'b1;
        slot_in_data_i[c*16 +: 16] <= v;
        @(posedge clk_i);
        slot_in_valid_i[c] <= 1'b0;
        @(posedge clk_i);
    endtask
    ////////////////////////////////////////
    task automatic s_regs;
        rdr(8'h18);
        chk(rd === 32'h1, "status reset value");
        rdr(8'h50);
        chk(rsp === `ALD_RESP_SLVERR && rd === 32'h0, "unmapped read");
        wr(8'h50, 32'h1);
        chk(rsp === `ALD_RESP_SLVERR, "unmapped write");
    endtask
    task automatic s_out;
        i_ald_mem_model.mem[0] = 32'h0000_0080;
        i_ald_mem_model.mem[1] = 32'hc000_0002;
        i_ald_mem_model.mem[32] = 32'hbbbb_aaaa;
        wr(8'h10, 32'h0);
        wr(8'h14, 32'h0);
        wr(8'h1c, 32'hd);
        poll(8'h18, `ALD_ST_IOC);
        chk(irq_o === 5'h02, "completion interrupt");
        req_out(1);
        chk(slot_data_o[31:16] === 16'haaaa && slot_valid_o[1] === 1'b1, "low half");
        req_out(1);
        chk(slot_data_o[31:16] === 16'hbbbb, "high half");
        req_out(1);
        chk(slot_data_o[31:16] === 16'h0, "zero fill at last index");
        rdr(8'h18);
        chk(rd === 32'h15, "halted with underrun");
        wr(8'h1c, 32'h0);
        req_out(1);
        chk(slot_valid_o[1] === 1'b0, "paused slot tag");
    endtask
    task automatic s_in;
        i_ald_mem_model.mem[16] = 32'h0000_00c0;
        i_ald_mem_model.mem[17] = 32'h8000_0002;
        i_ald_mem_model.mem[18] = 32'h0000_00c4;
        i_ald_mem_model.mem[19] = 32'h0000_0002;
        dly <= 2'd3;
        wr(8'h00, 32'h40);
        wr(8'h0c, 32'h9);
        smp_in(0, 16'h1111);
        smp_in(0, 16'h2222);
        poll(8'h08, `ALD_ST_IOC);
        chk(i_ald_mem_model.mem[48] === 32'h2222_1111 && irq_o[0] === 1'b0, "pair");
        repeat (10) smp_in(0, 16'h5555);
        rdr(8'h08);
        chk(rd[`ALD_ST_FE] === 1'b1 && irq_o[0] === 1'b1, "overrun");
        wr(8'h04, 32'h1);
        repeat (40) @(posedge clk_i);
        rdr(8'h08);
        chk(i_ald_mem_model.mem[49] === 32'h5555_5555, "restart data");
        chk(rd[12:8] === 5'h1 && rd[0] === 1'b1, "index advanced, halted");
    endtask
    initial
    begin
        repeat (20) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        s_regs();
        s_out();
        s_in();
        summarize();
    end
endmodule
